/* File: dv/mmr_ext_mem.sv */
// far-side model: external program and data memory segments
// assumes the decoder's registered selects, one clock, sync reset
`timescale 1ns/1ps
module mmr_ext_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // selects from the decoder
    input wire logic prog_valid,
    input wire mmr_pkg::mmr_mem_sel_t prog_sel,
    input wire logic data_valid,
    input wire mmr_pkg::mmr_mem_sel_t data_sel,
    // accesses seen on the external bus
    output logic [7:0] ext_count_q
);
    import mmr_pkg::*;
    logic [7:0] ext_count_d;
    // no read data port, so only count the strobed external accesses
    assign ext_count_d = ext_count_q + 8'(prog_valid && prog_sel.ext) + 8'(data_valid && data_sel.ext);
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_count_q <= 8'h00;
        end else begin
            ext_count_q <= ext_count_d;
        end
    end
endmodule : mmr_ext_mem

/* File: dv/mmr_tb.sv */
// self-checking bench for the memory map decoder
// assumes mmr_pkg and the hw files are compiled first
`timescale 1ns/1ps
module testbench;
    import mmr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ext_mem_cfg = 1'b1, prog_req = 1'b0, irq_take = 1'b0, data_req = 1'b0;
    logic reg_req = 1'b0, reg_work = 1'b0, rp_wr = 1'b0, mc_en_q, prog_valid_q, data_valid_q, reg_valid_q;
    logic [15:0] prog_addr = 16'h0000, data_addr = 16'h0000, pc_q;
    logic [2:0] irq_src = 3'h0;
    logic [7:0] reg_field = 8'h00, rp_wdata = 8'h00, rp_q, ext_count_q;
    mmr_mem_sel_t prog_sel_q, data_sel_q;
    mmr_reg_sel_t reg_sel_q;
    int failures = 0, cmp_count = 0, ticks = 0;
    mmr_top u_dut (.clk(clk), .rst(rst), .ext_mem_cfg(ext_mem_cfg), .prog_req(prog_req), .prog_addr(prog_addr),
        .irq_take(irq_take), .irq_src(irq_src), .data_req(data_req), .data_addr(data_addr), .reg_req(reg_req),
        .reg_work(reg_work), .reg_field(reg_field), .rp_wr(rp_wr), .rp_wdata(rp_wdata), .mc_en_q(mc_en_q),
        .pc_q(pc_q), .prog_valid_q(prog_valid_q), .prog_sel_q(prog_sel_q), .data_valid_q(data_valid_q),
        .data_sel_q(data_sel_q), .reg_valid_q(reg_valid_q), .reg_sel_q(reg_sel_q), .rp_q(rp_q));
    mmr_ext_mem u_mem (.clk(clk), .rst(rst), .prog_valid(prog_valid_q), .prog_sel(prog_sel_q),
        .data_valid(data_valid_q), .data_sel(data_sel_q), .ext_count_q(ext_count_q));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #50 clk = ~clk;
    end
    // ceiling well above the roughly 54 cycles the tests need
    always @(posedge clk) begin
        ticks++;
        if (ticks == 2000) begin
            failures++;
            complete_run();
        end
    end
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic m;
        check({1'b0, pc_q}, 17'h0000C);
        check({9'h000, rp_q}, 17'h00000);
        check({14'h0000, prog_valid_q, data_valid_q, reg_valid_q}, 17'h00000);
        // enable output lags the divider by one flop, still low at the first edge
        step();
        check({16'h0000, mc_en_q}, 17'h00000);
        for (int i = 0; i < 3; i++) begin
            m = mc_en_q;
            step();
            check({16'h0000, mc_en_q}, {16'h0000, ~m});
        end
    endtask : t_reset
    task automatic t_prog();
        logic [15:0] pa[4] = '{16'h0100, 16'h07FF, 16'h0800, 16'hFFFF};
        prog_req = 1'b1;
        foreach (pa[i]) begin
            prog_addr = pa[i];
            step();
            check({16'h0000, prog_valid_q}, 17'h00001);
            check(prog_sel_q, {pa[i] >= 16'h0800, pa[i]});
            check({1'b0, pc_q}, {1'b0, pa[i]});
        end
        // high fetch without external memory is dropped
        ext_mem_cfg = 1'b0;
        prog_addr = 16'h0800;
        step();
        prog_req = 1'b0;
        check({16'h0000, prog_valid_q}, 17'h00000);
        check({1'b0, pc_q}, 17'h0FFFF);
        ext_mem_cfg = 1'b1;
    endtask : t_prog
    task automatic t_irq();
        irq_take = 1'b1;
        for (int s = 0; s < 8; s++) begin
            irq_src = 3'(s);
            step();
            check({16'h0000, prog_valid_q}, {16'h0000, s < 6});
            check({1'b0, pc_q}, (s < 6) ? 17'(2 * s) : 17'h0000A);
            if (s < 6) check(prog_sel_q, 17'(2 * s));
        end
        // a vector taken with a fetch pending wins over the fetch
        irq_src = 3'h1;
        prog_req = 1'b1;
        prog_addr = 16'h0100;
        step();
        irq_take = 1'b0;
        prog_req = 1'b0;
        check({1'b0, pc_q}, 17'h00002);
        check(prog_sel_q, 17'h00002);
    endtask : t_irq
    task automatic t_data();
        logic [15:0] da[3] = '{16'h07FF, 16'h0800, 16'h1234};
        data_req = 1'b1;
        foreach (da[i]) begin
            data_addr = da[i];
            step();
            check({16'h0000, data_valid_q}, {16'h0000, da[i] >= 16'h0800});
            if (da[i] >= 16'h0800) check(data_sel_q, {1'b1, da[i]});
        end
        data_req = 1'b0;
        step();
        check({9'h000, ext_count_q}, 17'h00004);
    endtask : t_data
    task automatic t_regs();
        logic [7:0] ra[8] = '{8'h00, 8'h03, 8'h04, 8'h7F, 8'h80, 8'hEF, 8'hF0, 8'hFF};
        logic [1:0] c;
        reg_req = 1'b1;
        foreach (ra[i]) begin
            reg_field = ra[i];
            step();
            c = (ra[i] <= 8'h03) ? 2'h0 : (ra[i] <= 8'h7F) ? 2'h1 : 2'h2;
            check({16'h0000, reg_valid_q}, 17'h00001);
            if (ra[i] inside {[8'h80:8'hEF]}) check({16'h0000, reg_sel_q.hit}, 17'h00000);
            else check({6'h00, reg_sel_q}, {6'h00, 1'b1, c, ra[i]});
        end
        reg_req = 1'b0;
        // pointer then working field back to back
        rp_wr = 1'b1;
        rp_wdata = 8'hF0;
        step();
        rp_wr = 1'b0;
        reg_req = 1'b1;
        reg_work = 1'b1;
        reg_field = 8'h3C;
        check({9'h000, rp_q}, 17'h000F0);
        step();
        rp_wr = 1'b1;
        rp_wdata = 8'h1B;
        reg_field = 8'h05;
        check({6'h00, reg_sel_q}, {6'h00, 1'b1, 2'h2, 8'hFC});
        step();
        rp_wr = 1'b0;
        // pointer lands on the same edge, so this access still used the old group
        check({6'h00, reg_sel_q}, {6'h00, 1'b1, 2'h2, 8'hF5});
        step();
        reg_req = 1'b0;
        reg_work = 1'b0;
        check({6'h00, reg_sel_q}, {6'h00, 1'b1, 2'h1, 8'h15});
    endtask : t_regs
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) step();
        rst = 1'b0;
        t_reset();
        t_prog();
        t_irq();
        t_data();
        t_regs();
        complete_run();
    end
endmodule : testbench

/* File: hw/mmr_clk_div.sv */
// machine-cycle enable from the source clock
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`include "mmr_consts.svh"
module mmr_clk_div (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // machine-cycle enable
    output logic mc_en
);
    logic cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 1'b0;
        end else begin
            cnt_q <= ~cnt_q; // RULE10
        end
    end

    assign mc_en = cnt_q;

    mc_half_a: assert property (@(posedge clk) disable iff (rst) mc_en |=> !mc_en) // RULE10
        else $error("machine enable not at half rate");
endmodule : mmr_clk_div

/* File: hw/mmr_consts.svh */
// memory map constants for the microcomputer address decoder
// assumes it is included by bare name from files under hw/
// Operation
// RULE1: program addresses below 2048 come from on-chip storage, others go external
// RULE2: locations 0 to 11 hold six 16-bit interrupt vectors, source zero first
// RULE3: system reset loads the program counter with 12
// RULE4: external data segment starts at 2048 and holds mapped I/O devices
// RULE5: external program and data accesses use 16-bit addresses
// RULE6: register file has 124 general, 4 port and 16 control registers
// RULE7: 4-bit addressing sees 9 groups of 16 registers chosen by pointer
// RULE8: port registers sit at 0 to 3, control registers at 240 to 255
// RULE9: register addresses 128 to 239 are unimplemented and give undefined results
// RULE10: machine clock runs at half the source clock
// RULE11: working-register address is pointer high nibble joined to the 4-bit field
`ifndef MMR_CONSTS_SVH
`define MMR_CONSTS_SVH
`define MMR_ONCHIP_LIMIT 16'h0800
`define MMR_DATA_BASE 16'h0800
`define MMR_RESET_PC 16'h000C
`define MMR_VEC_COUNT 6
`define MMR_PORT_LAST 8'h03
`define MMR_GP_LAST 8'h7F
`define MMR_CTRL_FIRST 8'hF0
`define MMR_RP_ADDR 8'hFE
`define MMR_RP_RESET 8'h00
`define MMR_CLK_DIV 2
`endif

/* File: hw/mmr_pkg.sv */
// types for the memory map decoder
// assumes no include, mmr_consts.svh is not used here
package mmr_pkg;
    typedef enum logic [1:0] {
        mmr_reg_port,
        mmr_reg_gp,
        mmr_reg_ctrl,
        mmr_reg_none
    } mmr_reg_class_t;

    typedef struct packed {
        logic ext;
        logic [15:0] addr;
    } mmr_mem_sel_t;

    typedef struct packed {
        logic hit;
        mmr_reg_class_t cls;
        logic [7:0] addr;
    } mmr_reg_sel_t;
endpackage : mmr_pkg

/* File: hw/mmr_top.sv */
// memory map decoder: program, external data and register segments
// assumes the core supplies addresses and strobes synchronous to clk
`timescale 1ns/1ps
`include "mmr_consts.svh"
module mmr_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic ext_mem_cfg,
    // program fetch request
    input wire logic prog_req,
    input wire logic [15:0] prog_addr,
    // interrupt vector request
    input wire logic irq_take,
    input wire logic [2:0] irq_src,
    // data memory request
    input wire logic data_req,
    input wire logic [15:0] data_addr,
    // register file request
    input wire logic reg_req,
    input wire logic reg_work,
    input wire logic [7:0] reg_field,
    input wire logic rp_wr,
    input wire logic [7:0] rp_wdata,
    // machine timing
    output logic mc_en_q,
    // program counter
    output logic [15:0] pc_q,
    // program memory selection
    output logic prog_valid_q,
    output mmr_pkg::mmr_mem_sel_t prog_sel_q,
    // data memory selection
    output logic data_valid_q,
    output mmr_pkg::mmr_mem_sel_t data_sel_q,
    // register selection
    output logic reg_valid_q,
    output mmr_pkg::mmr_reg_sel_t reg_sel_q,
    output logic [7:0] rp_q
);
    import mmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic mmr_reg_class_t reg_class(input logic [7:0] a);
        if (a <= `MMR_PORT_LAST) begin
            reg_class = mmr_reg_port; // RULE8
        end else if (a <= `MMR_GP_LAST) begin
            reg_class = mmr_reg_gp; // RULE6
        end else if (a >= `MMR_CTRL_FIRST) begin
            reg_class = mmr_reg_ctrl; // RULE8
        end else begin
            reg_class = mmr_reg_none; // RULE9
        end
    endfunction : reg_class

    function automatic logic [15:0] vec_addr(input logic [2:0] src);
        vec_addr = {12'h000, src, 1'b0}; // RULE2
    endfunction : vec_addr

    ////////////////////////////////////////////////////////////////////////////
    // machine clock

    logic mc_en;

    mmr_clk_div u_div (
        .clk(clk),
        .rst(rst),
        .mc_en(mc_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // program segment

    wire logic prog_ext = ext_mem_cfg && (prog_addr >= `MMR_ONCHIP_LIMIT); // RULE1
    wire logic irq_ok = irq_take && (irq_src < 3'(`MMR_VEC_COUNT));
    wire logic [15:0] vec = vec_addr(irq_src);
    wire logic [15:0] pc_next = irq_ok ? vec : prog_addr;
    // without external memory configured, high fetches are not served at all
    wire logic prog_ok = prog_req && (prog_addr < `MMR_ONCHIP_LIMIT || ext_mem_cfg);

    ////////////////////////////////////////////////////////////////////////////
    // data segment

    // below the base the external segment has nothing
    wire logic data_ok = data_req && (data_addr >= `MMR_DATA_BASE); // RULE4

    ////////////////////////////////////////////////////////////////////////////
    // register segment

    wire logic [7:0] work_addr = {rp_q[7:4], reg_field[3:0]}; // RULE11 RULE7
    wire logic [7:0] reg_eff = reg_work ? work_addr : reg_field;
    wire mmr_reg_class_t cls = reg_class(reg_eff);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (rst) begin
            pc_q <= `MMR_RESET_PC; // RULE3
        end else if (irq_ok) begin
            pc_q <= vec; // RULE2
        end else if (prog_ok) begin
            pc_q <= pc_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prog_valid_q <= 1'b0;
            prog_sel_q <= '0;
        end else begin
            prog_valid_q <= prog_ok || irq_ok;
            prog_sel_q <= '{ext: prog_ext && !irq_ok, addr: pc_next}; // RULE1 RULE5
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_valid_q <= 1'b0;
            data_sel_q <= '0;
        end else begin
            data_valid_q <= data_ok;
            data_sel_q <= '{ext: data_ok, addr: data_addr}; // RULE4 RULE5
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rp_q <= `MMR_RP_RESET;
        end else if (rp_wr) begin
            rp_q <= rp_wdata; // RULE7
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_valid_q <= 1'b0;
            reg_sel_q <= '{hit: 1'b0, cls: mmr_reg_none, addr: 8'h00};
        end else begin
            reg_valid_q <= reg_req;
            reg_sel_q <= '{hit: reg_req && cls != mmr_reg_none, cls: cls, addr: reg_eff}; // RULE6 RULE9
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mc_en_q <= 1'b0;
        end else begin
            mc_en_q <= mc_en; // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // reset values, seen at the first edge after release
    reset_pc_a: assert property (@(posedge clk) // RULE3
        $fell(rst)
        |-> pc_q == 16'h000C)
        else $error("pc not 12 after reset");

    rp_reset_a: assert property (@(posedge clk) // RULE7
        $fell(rst)
        |-> rp_q == 8'h00)
        else $error("pointer not cleared by reset");

    valid_reset_a: assert property (@(posedge clk) // RULE1
        $fell(rst)
        |-> !prog_valid_q && !data_valid_q && !reg_valid_q)
        else $error("select strobe high after reset");

    mc_reset_a: assert property (@(posedge clk) // RULE10
        $fell(rst)
        |-> !mc_en_q)
        else $error("machine enable high after reset");

    // program segment
    onchip_low_a: assert property (@(posedge clk) disable iff (rst) // RULE1
        prog_req && !irq_take && prog_addr < 16'h0800
        |=> prog_valid_q && !prog_sel_q.ext)
        else $error("low program address went external");

    ext_high_a: assert property (@(posedge clk) disable iff (rst) // RULE1
        prog_req && !irq_take && ext_mem_cfg && prog_addr >= 16'h0800
        |=> prog_sel_q.ext && pc_q == $past(prog_addr))
        else $error("high program address not external");

    unconf_drop_a: assert property (@(posedge clk) disable iff (rst) // RULE1
        prog_req && !irq_take && !ext_mem_cfg && prog_addr >= 16'h0800
        |=> !prog_valid_q && $stable(pc_q))
        else $error("unconfigured high fetch served");

    prog_addr_a: assert property (@(posedge clk) disable iff (rst) // RULE5
        prog_req && !irq_take && (ext_mem_cfg || prog_addr < 16'h0800)
        |=> prog_valid_q && prog_sel_q.addr == $past(prog_addr))
        else $error("program address not carried whole");

    prog_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE1
        !prog_req && !irq_take
        |=> !prog_valid_q)
        else $error("program strobe without request");

    pc_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE3
        !prog_req && !irq_take
        |=> $stable(pc_q))
        else $error("pc moved without request");

    // interrupt vectors
    vector_a: assert property (@(posedge clk) disable iff (rst) // RULE2
        irq_take && irq_src < 3'd6
        |=> pc_q == {12'h000, $past(irq_src), 1'b0})
        else $error("wrong interrupt vector");

    vec_onchip_a: assert property (@(posedge clk) disable iff (rst) // RULE2
        irq_take && irq_src < 3'd6
        |=> prog_valid_q && !prog_sel_q.ext && prog_sel_q.addr == {12'h000, $past(irq_src), 1'b0})
        else $error("vector fetch not on chip");

    irq_ignore_a: assert property (@(posedge clk) disable iff (rst) // RULE2
        irq_take && irq_src >= 3'd6 && !prog_req
        |=> !prog_valid_q && $stable(pc_q))
        else $error("unknown interrupt source taken");

    // data segment
    data_base_a: assert property (@(posedge clk) disable iff (rst) // RULE4
        data_req
        |=> data_valid_q == ($past(data_addr) >= 16'h0800))
        else $error("data segment base wrong");

    data_addr_a: assert property (@(posedge clk) disable iff (rst) // RULE5
        data_req && data_addr >= 16'h0800
        |=> data_sel_q.addr == $past(data_addr))
        else $error("data address not carried whole");

    data_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE4
        !data_req
        |=> !data_valid_q)
        else $error("data strobe without request");

    // register segment
    work_reg_a: assert property (@(posedge clk) disable iff (rst) // RULE11
        reg_req && reg_work
        |=> reg_sel_q.addr == {$past(rp_q[7:4]), $past(reg_field[3:0])})
        else $error("working register address wrong");

    rp_write_a: assert property (@(posedge clk) disable iff (rst) // RULE7
        rp_wr
        |=> rp_q == $past(rp_wdata))
        else $error("pointer write lost");

    rp_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE7
        !rp_wr
        |=> $stable(rp_q))
        else $error("pointer moved without write");

    hole_a: assert property (@(posedge clk) disable iff (rst) // RULE9
        reg_req && !reg_work && reg_field >= 8'h80 && reg_field <= 8'hEF
        |=> !reg_sel_q.hit)
        else $error("unimplemented register hit");

    ctrl_class_a: assert property (@(posedge clk) disable iff (rst) // RULE8
        reg_req && !reg_work && reg_field >= 8'hF0
        |=> reg_sel_q.cls == mmr_reg_ctrl)
        else $error("control register misclassed");

    ctrl_work_a: assert property (@(posedge clk) disable iff (rst) // RULE8
        reg_req && reg_work && rp_q[7:4] == 4'hF
        |=> reg_sel_q.cls == mmr_reg_ctrl && reg_sel_q.hit)
        else $error("control group not reached");

    port_class_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        reg_req && !reg_work && reg_field <= 8'h03
        |=> reg_sel_q.cls == mmr_reg_port && reg_sel_q.hit)
        else $error("port register misclassed");

    gp_class_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        reg_req && !reg_work && reg_field >= 8'h04 && reg_field <= 8'h7F
        |=> reg_sel_q.cls == mmr_reg_gp && reg_sel_q.hit)
        else $error("general register misclassed");

    direct_addr_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        reg_req && !reg_work
        |=> reg_sel_q.addr == $past(reg_field))
        else $error("direct register address wrong");

    reg_valid_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        reg_req
        |=> reg_valid_q)
        else $error("register access lost");

    reg_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        !reg_req
        |=> !reg_valid_q && !reg_sel_q.hit)
        else $error("register strobe without request");

    // machine clock
    mc_rate_a: assert property (@(posedge clk) disable iff (rst) // RULE10
        mc_en_q
        |=> !mc_en_q ##1 mc_en_q)
        else $error("machine clock not half rate");

    // main scenarios
    ext_fetch_c: cover property (@(posedge clk) disable iff (rst) prog_valid_q && prog_sel_q.ext);
    irq_c: cover property (@(posedge clk) disable iff (rst) irq_take && irq_src == 3'd5);
    data_c: cover property (@(posedge clk) disable iff (rst) data_valid_q);
    work_c: cover property (@(posedge clk) disable iff (rst) reg_req && reg_work && rp_q == 8'hF0);
    hole_c: cover property (@(posedge clk) disable iff (rst) reg_valid_q && !reg_sel_q.hit);
endmodule : mmr_top
